//--- frame_bus_if.sv
`timescale 1ns/1ps
interface frame_bus_if;
    logic                 take;       // Full valid frame received, one cycle
    logic                 rw_read;    // Read when high
    gdsr_pkg::addr_t      addr;       // Register address
    gdsr_pkg::word_t      wdata;      // Write data
    logic                 start;      // Address complete pulse, latch response
    gdsr_pkg::addr_t      rsp_addr;   // Address used for response lookup
    gdsr_pkg::word_t      rsp_data;   // Addressed word content

    modport link (output take, output rw_read, output addr, output wdata,
                  output start, output rsp_addr, input rsp_data);
    modport bank (input take, input rw_read, input addr, input wdata,
                  input start, input rsp_addr, output rsp_data);
endinterface

//--- gate_driver_status_register_bank.sv
// Operation
// [R1] Status words 0x1-0x3 ignore writes
// [R2] Temperature flags and overheat warning in word 0x1
// [R3] Bit 5 live OR of six overcurrents
// [R4] Supply, pump and fault bits in word 0x1
// [R5] Any access to 0x1 services watchdog
// [R6] Six transistor overcurrent bits 10..5 at 0x2
// [R7] Amplifier overcurrent bits 2..0, bits 4:3 zero
// [R8] Lockout, watchdog, overheat faults at 0x3 bits 10..8
// [R9] Regulator, analog, low-side supply at 0x3 bits 6..4
// [R10] Pump faults at 0x3 bits 2..0
// [R11] All status bits zero after reset
// [R12] 16-bit frame: rw, address, data
// [R13] Response carries addressed word in low 11 bits
// [R14] Control registers default on sleep and power-up
// [R15] Reserved bits and word 0x8 read zero
// [R16] Unmapped addresses read all zeros
`timescale 1ns/1ps
`include "gdsr_consts.svh"
module gate_driver_status_register_bank (
    input  wire logic        clk_sys_i,
    input  wire logic        reset_n_i,
    // Serial link pins
    input  wire logic        sclk_i,
    input  wire logic        cs_n_i,
    input  wire logic        sdi_i,
    output logic             sdo_o,
    output logic             sdo_oe_o,
    // Sleep entry restores control defaults
    input  wire logic        sleep_enter_i,
    // Warning monitor levels
    input  wire logic        fault_i,
    input  wire logic        heat_flag_105_i,
    input  wire logic        heat_flag_125_i,
    input  wire logic        heat_flag_135_i,
    input  wire logic        heat_flag_175_i,
    input  wire logic        overheat_warning_i,
    input  wire logic        main_supply_low_warning_i,
    input  wire logic        main_supply_high_warning_i,
    input  wire logic        pump_low_warning_i,
    // Overcurrent monitors: [5]=high A .. [0]=low C
    input  wire logic [5:0]  overcurrent_i,
    // Amplifier overcurrent: [2]=C [1]=B [0]=A
    input  wire logic [2:0]  amp_overcurrent_i,
    // Chip fault monitors
    input  wire logic        main_supply_lockout_fault_i,
    input  wire logic        watchdog_expired_fault_i,
    input  wire logic        overheat_shutdown_fault_i,
    input  wire logic        regulator_low_fault_i,
    input  wire logic        analog_supply_low_fault_i,
    input  wire logic        low_side_supply_fault_i,
    input  wire logic        pump_low_fault_i,
    input  wire logic        pump_high_fault_i,
    input  wire logic        pump_absolute_high_fault_i,
    input  wire logic [10:0] gate_source_faults_i,
    // Results
    output logic             watchdog_service_o,
    output logic [10:0]      high_side_drive_control_o,
    output logic [10:0]      low_side_drive_control_o,
    output logic [10:0]      drive_mode_control_o,
    output logic [10:0]      chip_operation_control_o,
    output logic [10:0]      current_amplifier_control_o,
    output logic [10:0]      regulator_control_o,
    output logic [10:0]      drain_source_sense_control_o
);
    logic [1:0]          rst_sync_q;     // Reset release chain
    logic                rst_n;          // Released reset
    frame_bus_if         fb ();

    // Status words sampled from monitors (same clock domain)
    gdsr_pkg::word_t     warn_q;
    gdsr_pkg::word_t     oc_q;
    gdsr_pkg::word_t     chip_q;
    gdsr_pkg::word_t     gs_q;
    // Control words
    gdsr_pkg::word_t     hs_q;
    gdsr_pkg::word_t     ls_q;
    gdsr_pkg::word_t     mode_q;
    gdsr_pkg::word_t     op_q;
    gdsr_pkg::word_t     amp_q;
    gdsr_pkg::word_t     reg_q;
    gdsr_pkg::word_t     ds_q;
    logic                wd_q;           // Watchdog service pulse

    // Reset released through two flip-flops
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) rst_sync_q <= 2'b00;
        else rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    serial_frame_port u_port (
        .clk_sys_i (clk_sys_i),
        .rst_n     (rst_n),
        .sclk_i    (sclk_i),
        .cs_n_i    (cs_n_i),
        .sdi_i     (sdi_i),
        .sdo_o     (sdo_o),
        .sdo_oe_o  (sdo_oe_o),
        .fb        (fb)
    );

    // Warning word assembly; reserved bit 9 held zero
    gdsr_pkg::word_t warn_d;
    always_comb begin
        warn_d                 = `WORD_ZERO;
        warn_d[`W_FAULT]       = fault_i;                      // [R4]
        warn_d[`W_HEAT_175]    = heat_flag_175_i;              // [R2]
        warn_d[`W_SUPPLY_LOW]  = main_supply_low_warning_i;    // [R4]
        warn_d[`W_SUPPLY_HIGH] = main_supply_high_warning_i;   // [R4]
        warn_d[`W_OC_OR]       = |overcurrent_i;               // [R3]
        warn_d[`W_PUMP_LOW]    = pump_low_warning_i;           // [R4]
        warn_d[`W_HEAT_105]    = heat_flag_105_i;              // [R2]
        warn_d[`W_HEAT_125]    = heat_flag_125_i;              // [R2]
        warn_d[`W_HEAT_135]    = heat_flag_135_i;              // [R2]
        warn_d[`W_OVERHEAT]    = overheat_warning_i;           // [R2]
    end

    // Overcurrent word: bits 4:3 reserved zero
    gdsr_pkg::word_t oc_d;
    always_comb begin
        oc_d = `WORD_ZERO;
        oc_d[`OC_XTOR_HI:`OC_XTOR_LO] = overcurrent_i;         // [R6]
        oc_d[2:0] = amp_overcurrent_i;                         // [R7]
    end

    // Chip fault word: bits 7 and 3 reserved zero
    gdsr_pkg::word_t chip_d;
    always_comb begin
        chip_d               = `WORD_ZERO;
        chip_d[`C_LOCKOUT]   = main_supply_lockout_fault_i;    // [R8]
        chip_d[`C_WATCHDOG]  = watchdog_expired_fault_i;       // [R8]
        chip_d[`C_OVERHEAT]  = overheat_shutdown_fault_i;      // [R8]
        chip_d[`C_REGULATOR] = regulator_low_fault_i;          // [R9]
        chip_d[`C_ANALOG]    = analog_supply_low_fault_i;      // [R9]
        chip_d[`C_LS_SUPPLY] = low_side_supply_fault_i;        // [R9]
        chip_d[`C_PUMP_LOW]  = pump_low_fault_i;               // [R10]
        chip_d[`C_PUMP_HIGH] = pump_high_fault_i;              // [R10]
        chip_d[`C_PUMP_ABS]  = pump_absolute_high_fault_i;     // [R10]
    end

    // Status sampling; monitors own the latching, bank only mirrors
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            warn_q <= `WORD_ZERO;   // [R11]
            oc_q   <= `WORD_ZERO;   // [R11]
            chip_q <= `WORD_ZERO;   // [R11]
            gs_q   <= `WORD_ZERO;
        end else begin
            warn_q <= warn_d;
            oc_q   <= oc_d;
            chip_q <= chip_d;
            gs_q   <= gate_source_faults_i;
        end
    end

    // Write decode; status and reserved addresses have no strobe [R1]
    wire wr_en   = fb.take && !fb.rw_read;
    wire wr_hs   = wr_en && (fb.addr == `ADDR_HS_CTRL);
    wire wr_ls   = wr_en && (fb.addr == `ADDR_LS_CTRL);
    wire wr_mode = wr_en && (fb.addr == `ADDR_MODE_CTRL);
    wire wr_op   = wr_en && (fb.addr == `ADDR_OP_CTRL);
    wire wr_amp  = wr_en && (fb.addr == `ADDR_AMP_CTRL);
    wire wr_reg  = wr_en && (fb.addr == `ADDR_REG_CTRL);
    wire wr_ds   = wr_en && (fb.addr == `ADDR_DS_CTRL);

    // Control words; sleep entry forces defaults, taking priority
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            hs_q   <= `RST_HS_CTRL;   // [R14]
            ls_q   <= `RST_LS_CTRL;
            mode_q <= `RST_MODE_CTRL;
            op_q   <= `RST_OP_CTRL;
            amp_q  <= `RST_AMP_CTRL;
            reg_q  <= `RST_REG_CTRL;
            ds_q   <= `RST_DS_CTRL;
        end else if (sleep_enter_i) begin
            hs_q   <= `RST_HS_CTRL;   // [R14]
            ls_q   <= `RST_LS_CTRL;
            mode_q <= `RST_MODE_CTRL;
            op_q   <= `RST_OP_CTRL;
            amp_q  <= `RST_AMP_CTRL;
            reg_q  <= `RST_REG_CTRL;
            ds_q   <= `RST_DS_CTRL;
        end else begin
            if (wr_hs)   hs_q   <= fb.wdata;
            if (wr_ls)   ls_q   <= fb.wdata;
            if (wr_mode) mode_q <= fb.wdata;
            if (wr_op)   op_q   <= fb.wdata;
            if (wr_amp)  amp_q  <= fb.wdata;
            if (wr_reg)  reg_q  <= fb.wdata;
            if (wr_ds)   ds_q   <= fb.wdata;
        end
    end

    // Watchdog service on any full frame to the warning word
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) wd_q <= 1'b0;
        else wd_q <= fb.take && (fb.addr == `ADDR_WARN);   // [R5]
    end

    // Response lookup; reserved word and unmapped read zero
    gdsr_pkg::word_t rsp;
    always_comb begin
        unique case (fb.rsp_addr)
            `ADDR_WARN:       rsp = warn_q;
            `ADDR_FAULT_OC:   rsp = oc_q;
            `ADDR_FAULT_CHIP: rsp = chip_q;
            `ADDR_FAULT_GS:   rsp = gs_q;
            `ADDR_HS_CTRL:    rsp = hs_q;
            `ADDR_LS_CTRL:    rsp = ls_q;
            `ADDR_MODE_CTRL:  rsp = mode_q;
            `ADDR_OP_CTRL:    rsp = op_q;
            `ADDR_AMP_CTRL:   rsp = amp_q;
            `ADDR_REG_CTRL:   rsp = reg_q;
            `ADDR_DS_CTRL:    rsp = ds_q;
            default:          rsp = `WORD_ZERO;   // [R15] [R16]
        endcase
    end
    assign fb.rsp_data = rsp;   // [R13]

    assign watchdog_service_o           = wd_q;
    assign high_side_drive_control_o    = hs_q;
    assign low_side_drive_control_o     = ls_q;
    assign drive_mode_control_o         = mode_q;
    assign chip_operation_control_o     = op_q;
    assign current_amplifier_control_o  = amp_q;
    assign regulator_control_o          = reg_q;
    assign drain_source_sense_control_o = ds_q;
endmodule

//--- gate_driver_status_register_bank_bench.sv
`timescale 1ns/1ps
module gate_driver_status_register_bank_bench;
    logic        clk_sys_i;       // System clock
    logic        reset_n_i;       // Reset, active low
    logic        sclk;            // Link clock from master
    logic        cs_n;            // Select, active low
    logic        sdi;             // Master to device data
    logic        sdo;             // Device to master data
    logic        sdo_oe;          // Device output enable
    logic        sleep;           // Sleep entry request
    logic        wd;              // Watchdog service pulse
    logic [8:0]  warn_in;         // Warning monitors, fault on top
    logic [5:0]  oc;              // Transistor overcurrent monitors
    logic [2:0]  amp;             // Amplifier overcurrent monitors
    logic [8:0]  chip_in;         // Chip fault monitors, lockout on top
    logic [10:0] gs;              // Gate-source fault bus
    logic [10:0] ctrl [0:6];      // Control word outputs
    logic [10:0] shadow [0:15];   // Expected control contents
    logic [10:0] r;               // Last response
    logic [10:0] d;               // Write data
    logic [3:0]  a;               // Address under test
    int          err_count;
    int          tests_run;
    int          wd_seen;

    gate_driver_status_register_bank dut (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .sclk_i(sclk), .cs_n_i(cs_n),
        .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .sleep_enter_i(sleep),
        .fault_i(warn_in[8]), .heat_flag_175_i(warn_in[7]),
        .main_supply_low_warning_i(warn_in[6]), .main_supply_high_warning_i(warn_in[5]),
        .pump_low_warning_i(warn_in[4]), .heat_flag_105_i(warn_in[3]),
        .heat_flag_125_i(warn_in[2]), .heat_flag_135_i(warn_in[1]),
        .overheat_warning_i(warn_in[0]), .overcurrent_i(oc), .amp_overcurrent_i(amp),
        .main_supply_lockout_fault_i(chip_in[8]), .watchdog_expired_fault_i(chip_in[7]),
        .overheat_shutdown_fault_i(chip_in[6]), .regulator_low_fault_i(chip_in[5]),
        .analog_supply_low_fault_i(chip_in[4]), .low_side_supply_fault_i(chip_in[3]),
        .pump_low_fault_i(chip_in[2]), .pump_high_fault_i(chip_in[1]),
        .pump_absolute_high_fault_i(chip_in[0]), .gate_source_faults_i(gs),
        .watchdog_service_o(wd), .high_side_drive_control_o(ctrl[0]),
        .low_side_drive_control_o(ctrl[1]), .drive_mode_control_o(ctrl[2]),
        .chip_operation_control_o(ctrl[3]), .current_amplifier_control_o(ctrl[4]),
        .regulator_control_o(ctrl[5]), .drain_source_sense_control_o(ctrl[6])
    );

    // Released output line reads inverted, there is no pull resistor
    spi_master_model partner (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi),
                              .sdo_i(sdo_oe ? sdo : ~sdo));

    // 200 MHz clock
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    // Count service pulses
    always @(posedge clk_sys_i) begin
        if (wd === 1'b1) begin
            wd_seen++;
        end
    end

    // Expected word at an address, from monitor levels and written data
    function automatic logic [10:0] exp_word(input logic [3:0] x);
        case (x)
            4'h1: return {warn_in[8], 1'h0, warn_in[7:5], |oc, warn_in[4:0]};
            4'h2: return {oc, 2'h0, amp};
            4'h3: return {chip_in[8:6], 1'h0, chip_in[5:3], 1'h0, chip_in[2:0]};
            4'h4: return gs;
            4'h5, 4'h6, 4'h7, 4'h9, 4'ha, 4'hb, 4'hc: return shadow[x];
            default: return 11'h000;
        endcase
    endfunction

    // Control output that belongs to an address
    function automatic logic [10:0] ctrl_out(input logic [3:0] x);
        return (x == 4'h8) ? 11'h000 : ctrl[(x < 4'h8) ? x - 4'h5 : x - 4'h6];
    endfunction

    task automatic check(input logic [10:0] got, input logic [10:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One frame, random link speed; low 11 response bits kept
    task automatic frame(input logic rd, input logic [3:0] x, input logic [10:0] v,
                         input int n);
        logic [15:0] rx;
        partner.xfer({rd, x, v}, n, 1'($urandom), rx);
        r = rx[10:0];
    endtask

    // New monitor levels; early rounds walk one overcurrent bit
    task automatic stir(input int i);
        @(posedge clk_sys_i);
        warn_in <= 9'($urandom);
        oc <= (i < 6) ? 6'(1 << i) : 6'($urandom);
        amp <= 3'($urandom);
        chip_in <= 9'($urandom);
        gs <= 11'($urandom);
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        #(450_000);
        err_count++;
        $display("Error at %0t: run timed out", $time);
        complete_run();
    end

    initial begin
        err_count = 0;
        tests_run = 0;
        wd_seen = 0;
        reset_n_i = 1'b0;
        sleep = 1'b0;
        {warn_in, oc, amp, chip_in, gs} = '0;
        for (int k = 0; k < 16; k++) shadow[k] = 11'h000;
        r = 11'($urandom(32'hc451_272a));
        repeat (6) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        // Every address after power-up, unmapped ones too
        for (int k = 0; k < 16; k++) begin
            frame(1'b1, 4'(k), 11'h000, 16);
            check(r, exp_word(4'(k)), "reset read");
        end
        $display("Test reset values done");
        for (int i = 0; i < 24; i++) begin
            stir(i);
            a = 4'(1 + (i % 4));
            frame(1'b1, a, 11'($urandom), 16);
            check(r, exp_word(a), "status read");
        end
        $display("Test status words done");
        for (int k = 1; k < 5; k++) begin
            frame(1'b0, 4'(k), 11'h7ff, 16);
            check(r, exp_word(4'(k)), "write response");
            frame(1'b1, 4'(k), 11'h000, 16);
            check(r, exp_word(4'(k)), "read-only word");
        end
        $display("Test read-only done");
        wd_seen = 0;
        frame(1'b1, 4'h1, 11'h000, 16);
        frame(1'b0, 4'h1, 11'h000, 16);
        frame(1'b1, 4'h2, 11'h000, 16);
        frame(1'b1, 4'h1, 11'h000, 15);
        frame(1'b1, 4'h1, 11'h000, 17);
        check(11'(wd_seen), 11'h002, "watchdog pulses");
        $display("Test watchdog done");
        for (int k = 0; k < 16; k++) begin
            a = 4'(5 + (k % 8));
            d = (k < 8) ? 11'($urandom) : 11'h7ff;
            frame(1'b0, a, d, 16);
            check(r, exp_word(a), "write old value");
            if (a != 4'h8) shadow[a] = d;
            check(ctrl_out(a), exp_word(a), "control output");
            frame(1'b1, a, 11'h000, 16);
            check(r, exp_word(a), "control readback");
        end
        // Broken frames must not write
        frame(1'b0, 4'h5, 11'h123, 15);
        frame(1'b0, 4'h6, 11'h321, 17);
        check(ctrl[0], shadow[5], "short frame write");
        check(ctrl[1], shadow[6], "long frame write");
        $display("Test control words done");
        @(posedge clk_sys_i);
        sleep <= 1'b1;
        @(posedge clk_sys_i);
        sleep <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        for (int k = 0; k < 7; k++) check(ctrl[k], 11'h000, "sleep default");
        $display("Test sleep done");
        complete_run();
    end
endmodule

//--- gdsr_consts.svh
`ifndef GDSR_CONSTS_SVH
`define GDSR_CONSTS_SVH

// Frame layout
`define FRAME_BITS      5'd16
`define FRAME_RW_BIT    15
`define FRAME_ADDR_HI   14
`define FRAME_ADDR_LO   11
`define FRAME_DATA_HI   10
`define WORD_ZERO       11'h000

// Register addresses
`define ADDR_WARN       4'h1
`define ADDR_FAULT_OC   4'h2
`define ADDR_FAULT_CHIP 4'h3
`define ADDR_FAULT_GS   4'h4
`define ADDR_HS_CTRL    4'h5
`define ADDR_LS_CTRL    4'h6
`define ADDR_MODE_CTRL  4'h7
`define ADDR_RSVD_WORD  4'h8
`define ADDR_OP_CTRL    4'h9
`define ADDR_AMP_CTRL   4'ha
`define ADDR_REG_CTRL   4'hb
`define ADDR_DS_CTRL    4'hc

// Control register reset values
`define RST_HS_CTRL     11'h000
`define RST_LS_CTRL     11'h000
`define RST_MODE_CTRL   11'h000
`define RST_OP_CTRL     11'h000
`define RST_AMP_CTRL    11'h000
`define RST_REG_CTRL    11'h000
`define RST_DS_CTRL     11'h000

// Warning word bit positions
`define W_FAULT         10
`define W_HEAT_175      8
`define W_SUPPLY_LOW    7
`define W_SUPPLY_HIGH   6
`define W_OC_OR         5
`define W_PUMP_LOW      4
`define W_HEAT_105      3
`define W_HEAT_125      2
`define W_HEAT_135      1
`define W_OVERHEAT      0

// Overcurrent word: bits 10..5 transistors, 2..0 amplifiers
`define OC_XTOR_LO      5
`define OC_XTOR_HI      10

// Chip fault word bit positions
`define C_LOCKOUT       10
`define C_WATCHDOG      9
`define C_OVERHEAT      8
`define C_REGULATOR     6
`define C_ANALOG        5
`define C_LS_SUPPLY     4
`define C_PUMP_LOW      2
`define C_PUMP_HIGH     1
`define C_PUMP_ABS      0

`endif

//--- gdsr_pkg.sv
package gdsr_pkg;
    // Serial frame phases
    typedef enum logic [1:0] {
        FR_IDLE,
        FR_SHIFT,
        FR_DONE
    } frame_state_t;

    typedef logic [10:0] word_t;
    typedef logic [3:0]  addr_t;
endpackage

//--- gdsr_props.sv
`timescale 1ns/1ps
module gdsr_props (
    input  wire logic        clk_sys_i,
    input  wire logic        reset_n_i,
    input  wire logic        sclk_i,
    input  wire logic        cs_n_i,
    input  wire logic        sdo_o,
    input  wire logic        sdo_oe_o,
    input  wire logic        sleep_enter_i,
    input  wire logic        watchdog_service_o,
    input  wire logic [10:0] high_side_drive_control_o,
    input  wire logic [10:0] low_side_drive_control_o,
    input  wire logic [10:0] drive_mode_control_o,
    input  wire logic [10:0] chip_operation_control_o,
    input  wire logic [10:0] current_amplifier_control_o,
    input  wire logic [10:0] regulator_control_o,
    input  wire logic [10:0] drain_source_sense_control_o
);
    logic [3:0]  idle_q;    // Cycles with select high and no sleep
    logic [3:0]  idle_d;    // Next idle count, saturating
    logic [76:0] ctrl_all;  // All control words side by side

    assign ctrl_all = {high_side_drive_control_o, low_side_drive_control_o,
                       drive_mode_control_o, chip_operation_control_o,
                       current_amplifier_control_o, regulator_control_o,
                       drain_source_sense_control_o};
    // Saturate so a long idle never wraps back into the write window
    assign idle_d = (!cs_n_i || sleep_enter_i) ? 4'h0
                  : ((idle_q == 4'hf) ? idle_q : idle_q + 4'h1);

    // Idle counter
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            idle_q <= 4'h0;
        end else begin
            idle_q <= idle_d;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    chk_oe_on_select: assert property ($fell(cs_n_i) |-> ##[2:6] sdo_oe_o)
        else $error("output enable late after select");
    chk_oe_off_deselect: assert property ($rose(cs_n_i) |-> ##[2:6] !sdo_oe_o)
        else $error("output enable stuck after deselect");
    chk_oe_idle_low: assert property (cs_n_i [*8] |-> !sdo_oe_o)
        else $error("output driven while deselected");
    chk_sdo_on_rise: assert property ((sdo_oe_o && $past(sdo_oe_o, 2) && $changed(sdo_o))
        |-> sclk_i)
        else $error("serial output changed outside high clock phase");
    chk_wd_single_pulse: assert property (watchdog_service_o |=> !watchdog_service_o)
        else $error("watchdog service longer than one cycle");
    chk_wd_after_frame: assert property (watchdog_service_o
        |-> cs_n_i && !$past(cs_n_i, 8))
        else $error("watchdog service without a finished frame");
    chk_sleep_clears_ctrl: assert property (sleep_enter_i |-> ##[1:3] (ctrl_all == '0))
        else $error("sleep did not restore control defaults");
    chk_ctrl_idle_hold: assert property ((idle_q > 4'hc) |-> $stable(ctrl_all))
        else $error("control word changed without a frame");
endmodule

bind gate_driver_status_register_bank gdsr_props u_props (
    .clk_sys_i, .reset_n_i, .sclk_i, .cs_n_i, .sdo_o, .sdo_oe_o, .sleep_enter_i,
    .watchdog_service_o, .high_side_drive_control_o, .low_side_drive_control_o,
    .drive_mode_control_o, .chip_operation_control_o, .current_amplifier_control_o,
    .regulator_control_o, .drain_source_sense_control_o
);

//--- serial_frame_port.sv
`timescale 1ns/1ps
`include "gdsr_consts.svh"
module serial_frame_port (
    input  wire logic   clk_sys_i,
    input  wire logic   rst_n,
    input  wire logic   sclk_i,
    input  wire logic   cs_n_i,
    input  wire logic   sdi_i,
    output logic        sdo_o,
    output logic        sdo_oe_o,
    frame_bus_if.link   fb
);
    // Three-stage synchronisers; stage 0 feeds only stage 1
    logic [2:0] sclk_q;
    logic [2:0] cs_q;
    logic [2:0] sdi_q;
    logic       sclk_s;         // Filtered clock level
    logic       cs_n_s;         // Filtered select level
    logic [4:0] count_q;        // Bits captured this frame
    logic [15:0] shin_q;        // Incoming frame
    logic [15:0] shout_q;       // Outgoing response
    logic       sdo_q;
    gdsr_pkg::frame_state_t st_q;

    // Edge qualified once stages 1 and 2 agree
    wire sclk_rise = sclk_q[1] & sclk_q[2] & ~sclk_s;
    wire sclk_fall = ~sclk_q[1] & ~sclk_q[2] & sclk_s;
    wire cs_fall   = ~cs_q[1] & ~cs_q[2] & cs_n_s;
    wire cs_rise   = cs_q[1] & cs_q[2] & ~cs_n_s;

    // Synchroniser chains
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q <= 3'h0;
            cs_q   <= 3'h7;
            sdi_q  <= 3'h0;
        end else begin
            sclk_q <= {sclk_q[1:0], sclk_i};
            cs_q   <= {cs_q[1:0], cs_n_i};
            sdi_q  <= {sdi_q[1:0], sdi_i};
        end
    end

    // Debounced levels, updated only on agreement
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            sclk_s <= 1'b0;
            cs_n_s <= 1'b1;
        end else begin
            if (sclk_rise || sclk_fall) sclk_s <= sclk_q[2];
            if (cs_fall || cs_rise) cs_n_s <= cs_q[2];
        end
    end

    // Frame state, bit count and shift registers [R12]
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            st_q    <= gdsr_pkg::FR_IDLE;
            count_q <= 5'h0;
            shin_q  <= 16'h0000;
            shout_q <= 16'h0000;
            sdo_q   <= 1'b0;
        end else begin
            unique case (st_q)
                gdsr_pkg::FR_IDLE: begin
                    if (cs_fall) begin
                        st_q    <= gdsr_pkg::FR_SHIFT;
                        count_q <= 5'h0;
                    end
                end
                gdsr_pkg::FR_SHIFT: begin
                    // Response latched at the 5th captured bit, address complete
                    if (sclk_rise && count_q == 5'h0) begin
                        sdo_q <= shout_q[15];
                    end else if (sclk_rise) begin
                        sdo_q   <= shout_q[14];
                        shout_q <= {shout_q[14:0], 1'b0};
                    end
                    if (sclk_fall) begin
                        shin_q  <= {shin_q[14:0], sdi_q[2]};
                        count_q <= count_q + 5'h1;
                    end
                    // Word MSB in bit 14, so it leaves on the 6th rising edge
                    if (fb.start) begin
                        shout_q <= {1'b0, fb.rsp_data, 4'h0}; // [R13]
                    end
                    if (cs_rise) st_q <= gdsr_pkg::FR_DONE;
                end
                gdsr_pkg::FR_DONE: begin
                    st_q <= gdsr_pkg::FR_IDLE;
                end
            endcase
        end
    end

    // Response comes from the address in bits 14:11, known after 5 bits
    assign fb.start    = (st_q == gdsr_pkg::FR_SHIFT) && sclk_fall && (count_q == 5'h4);
    assign fb.rsp_addr = {shin_q[2:0], sdi_q[2]};
    // Frames whose bit count is not 16 modulo 32 are dropped, the 5-bit count wraps [R12]
    assign fb.take     = (st_q == gdsr_pkg::FR_DONE) && (count_q == `FRAME_BITS);
    assign fb.rw_read  = shin_q[`FRAME_RW_BIT];
    assign fb.addr     = shin_q[`FRAME_ADDR_HI:`FRAME_ADDR_LO];
    assign fb.wdata    = shin_q[`FRAME_DATA_HI:0];
    assign sdo_o       = sdo_q;
    assign sdo_oe_o    = ~cs_n_s;
endmodule

//--- spi_master_model.sv
`timescale 1ns/1ps
module spi_master_model (
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      sdi_o,
    input  wire logic sdo_i
);
    // Link clock stands still low outside frames
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o = 1'b0;
    end

    // One frame; n other than 16 is a deliberately broken frame
    task automatic xfer(input logic [15:0] tx, input int n, input logic slow,
                        output logic [15:0] rx);
        realtime h;
        h = slow ? 96.0 : 32.0;  // 64 ns period, or a slow master
        rx = 16'h0000;
        #(h);
        cs_n_o = 1'b0;
        #(h);
        for (int i = 0; i < n; i++) begin
            sclk_o = 1'b1;
            sdi_o = (i < 16) ? tx[15 - i] : ~sdi_o;
            #(h);
            sclk_o = 1'b0;
            rx = {rx[14:0], sdo_i};
            #(h);
        end
        cs_n_o = 1'b1;
        // Released data line must not keep showing the last bit
        sdi_o = ~sdi_o;
        #(520.0);
    endtask
endmodule
